// *** design/conceal_pkg.sv ***
// package: shared types and constants for the slice error concealment block
package conceal_pkg;

  // ==========================================================
  // widths
  // ==========================================================
  localparam int CTB_W = 10; // ctb coordinate width

  // ==========================================================
  // slice type encoding
  // ==========================================================
  typedef enum logic [1:0] {
    SLICE_B = 2'h0,
    SLICE_P = 2'h1,
    SLICE_I = 2'h2
  } slice_kind_e;

  // ==========================================================
  // block build modes emitted with every ctb
  // ==========================================================
  typedef enum logic [1:0] {
    BUILD_DECODED = 2'h0, // normally decoded ctb
    BUILD_PLANAR = 2'h1,  // concealed with intra planar prediction
    BUILD_SKIP = 2'h2,    // concealed as skipped
    BUILD_FORCED = 2'h3   // errored ctb written out by substitution
  } build_mode_e;

  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic [CTB_W-1:0] cur_slice_col;
    logic [CTB_W-1:0] cur_slice_row;
    logic [CTB_W-1:0] next_slice_col;
    logic [CTB_W-1:0] next_slice_row;
    logic final_slice_flag;
    slice_kind_e slice_kind;
  } slice_cmd_s;

  typedef struct packed {
    logic [CTB_W-1:0] col;
    logic [CTB_W-1:0] row;
    build_mode_e mode;
  } ctb_out_s;

  // reset value of the emitted ctb record
  localparam ctb_out_s CTB_OUT_RST = '{col: '0, row: '0, mode: BUILD_DECODED};

endpackage

// *** design/slice_conceal.sv ***
// design: per-slice ctb walk with always-on error concealment
`timescale 1ns/10ps
// What this block does
// - concealment is always on, no disable
// - every workload finishes, never hangs
// - command carries current and next ctb starts
// - final flag selects picture end as endpoint
// - slice type selects concealed block construction
// - clean stream decodes start through next-minus-one
// - short slice concealed up to next start
// - errored current ctb still written out
// - final slice concealed to picture last ctb
// - intra slice conceals with planar prediction
// - predicted slice conceals as skipped
// - bi-predicted slice conceals as skipped
module slice_conceal
  import conceal_pkg::*;
#(
  parameter int W = CTB_W
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  // picture state: size in ctbs
  input wire logic [W-1:0] i_pic_width_ctb,
  input wire logic [W-1:0] i_pic_height_ctb,
  // slice command handshake
  input wire logic i_cmd_valid,
  input wire slice_cmd_s i_cmd,
  output logic o_cmd_ready,
  // parser: one decoded ctb per pulse, error stops the slice
  input wire logic i_dec_ctb_done,
  input wire logic i_dec_ctb_error,
  input wire logic i_dec_slice_end,
  // ctb output stream
  output logic o_ctb_valid,
  output ctb_out_s o_ctb,
  // slice finished pulse
  output logic o_slice_done
);

  // ==========================================================
  // state
  // ==========================================================
  typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_CONCEAL} walk_state_e;

  walk_state_e state_q, state_d;       // walk phase
  logic [W-1:0] col_q, col_d;          // next ctb position to emit
  logic [W-1:0] row_q, row_d;
  logic [W-1:0] end_col_q, end_col_d;  // last ctb of this slice
  logic [W-1:0] end_row_q, end_row_d;
  slice_kind_e kind_q, kind_d;         // latched slice type
  logic ready_q, ready_d;
  logic vld_q, vld_d;
  ctb_out_s ctb_q, ctb_d;
  logic done_q, done_d;
  logic at_end;                        // current position is slice end

  // advance one ctb in raster order, wrapping at picture width
  function automatic logic [2*W-1:0] step(input logic [W-1:0] c,
                                          input logic [W-1:0] r,
                                          input logic [W-1:0] wid);
    if (c + W'(1) >= wid) begin
      step = {W'(0), W'(r + W'(1))};
    end else begin
      step = {W'(c + W'(1)), r};
    end
  endfunction

  // concealment mode from slice type; intra gets planar, others skip
  function automatic build_mode_e conceal_mode(input slice_kind_e k);
    if (k == SLICE_I) begin
      conceal_mode = BUILD_PLANAR;
    end else begin
      conceal_mode = BUILD_SKIP;
    end
  endfunction

  assign at_end = (col_q == end_col_q) && (row_q == end_row_q);

  // ==========================================================
  // next-state logic
  // ==========================================================
  // there is deliberately no concealment enable input at all
  always_comb begin
    logic [2*W-1:0] nx;
    nx = step(col_q, row_q, i_pic_width_ctb);
    state_d = state_q;
    col_d = col_q;
    row_d = row_q;
    end_col_d = end_col_q;
    end_row_d = end_row_q;
    kind_d = kind_q;
    ready_d = ready_q;
    vld_d = 1'b0;
    ctb_d = ctb_q;
    done_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (i_cmd_valid && ready_q) begin
          col_d = i_cmd.cur_slice_col;
          row_d = i_cmd.cur_slice_row;
          kind_d = i_cmd.slice_kind;
          ready_d = 1'b0;
          state_d = ST_DECODE;
          if (i_cmd.final_slice_flag) begin
            end_col_d = i_pic_width_ctb - W'(1);
            end_row_d = i_pic_height_ctb - W'(1);
          end else if (i_cmd.next_slice_col == '0) begin
            // next start at row head: end is last column of row above
            end_col_d = i_pic_width_ctb - W'(1);
            end_row_d = i_cmd.next_slice_row - W'(1);
          end else begin
            end_col_d = i_cmd.next_slice_col - W'(1);
            end_row_d = i_cmd.next_slice_row;
          end
        end
      end
      ST_DECODE: begin
        if (i_dec_ctb_done || i_dec_ctb_error) begin
          // error: errored ctb still leaves as a substitute
          vld_d = 1'b1;
          ctb_d.col = col_q;
          ctb_d.row = row_q;
          if (i_dec_ctb_error) begin
            ctb_d.mode = BUILD_FORCED;
          end else begin
            ctb_d.mode = BUILD_DECODED;
          end
          col_d = nx[2*W-1:W];
          row_d = nx[W-1:0];
          if (at_end) begin
            state_d = ST_IDLE;
            ready_d = 1'b1;
            done_d = 1'b1;
          end else if (i_dec_ctb_error) begin
            state_d = ST_CONCEAL;
          end
        end else if (i_dec_slice_end) begin
          // parser stopped early with ctbs outstanding
          state_d = ST_CONCEAL;
        end
      end
      ST_CONCEAL: begin
        // one concealed ctb per cycle; position bounded so no hang
        vld_d = 1'b1;
        ctb_d.col = col_q;
        ctb_d.row = row_q;
        ctb_d.mode = conceal_mode(kind_q);
        col_d = nx[2*W-1:W];
        row_d = nx[W-1:0];
        if (at_end || row_q >= i_pic_height_ctb) begin
          state_d = ST_IDLE;
          ready_d = 1'b1;
          done_d = 1'b1;
        end
      end
      default: begin
        state_d = ST_IDLE;
        ready_d = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge i_clk_sys or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= ST_IDLE;
      col_q <= '0;
      row_q <= '0;
      end_col_q <= '0;
      end_row_q <= '0;
      kind_q <= SLICE_I;
      ready_q <= 1'b1;
      vld_q <= 1'b0;
      ctb_q <= CTB_OUT_RST;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      col_q <= col_d;
      row_q <= row_d;
      end_col_q <= end_col_d;
      end_row_q <= end_row_d;
      kind_q <= kind_d;
      ready_q <= ready_d;
      vld_q <= vld_d;
      ctb_q <= ctb_d;
      done_q <= done_d;
    end
  end

  // outputs straight from flip-flops
  assign o_cmd_ready = ready_q;
  assign o_ctb_valid = vld_q;
  assign o_ctb = ctb_q;
  assign o_slice_done = done_q;

  // ==========================================================
  // assertions
  // ==========================================================
  property p_intra_planar;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (state_q == ST_CONCEAL && kind_q == SLICE_I)
        |=> (o_ctb_valid && o_ctb.mode == BUILD_PLANAR);
  endproperty
  a_intra_planar: assert property (p_intra_planar)
    else $error("intra concealed ctb not planar");

  property p_inter_skip;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (state_q == ST_CONCEAL && kind_q != SLICE_I)
        |=> (o_ctb.mode == BUILD_SKIP);
  endproperty
  a_inter_skip: assert property (p_inter_skip)
    else $error("inter concealed ctb not skipped");

  property p_error_forced;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (state_q == ST_DECODE && i_dec_ctb_error)
        |=> (o_ctb_valid && o_ctb.mode == BUILD_FORCED
             && o_ctb.col == $past(col_q));
  endproperty
  a_error_forced: assert property (p_error_forced)
    else $error("errored ctb not written out");

  property p_raster;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (state_q == ST_CONCEAL && col_q + W'(1) < i_pic_width_ctb)
        |=> (col_q == $past(col_q) + W'(1) && row_q == $past(row_q));
  endproperty
  a_raster: assert property (p_raster)
    else $error("concealment not in raster order");

  property p_end_done;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (state_q == ST_CONCEAL && at_end) |=> (o_slice_done && o_cmd_ready);
  endproperty
  a_end_done: assert property (p_end_done)
    else $error("slice end did not finish slice");

  property p_final_end;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (state_q == ST_IDLE && i_cmd_valid && ready_q && i_cmd.final_slice_flag)
        |=> (end_row_q == i_pic_height_ctb - W'(1));
  endproperty
  a_final_end: assert property (p_final_end)
    else $error("final slice end not picture end");

  property p_next_end;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (state_q == ST_IDLE && i_cmd_valid && ready_q
       && !i_cmd.final_slice_flag && i_cmd.next_slice_col != '0)
        |=> (end_col_q == $past(i_cmd.next_slice_col) - W'(1));
  endproperty
  a_next_end: assert property (p_next_end)
    else $error("slice end not before next start");

  property p_short_conceal;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (state_q == ST_DECODE && i_dec_slice_end && !i_dec_ctb_done
       && !i_dec_ctb_error) |=> (state_q == ST_CONCEAL) ##1 o_ctb_valid;
  endproperty
  a_short_conceal: assert property (p_short_conceal)
    else $error("early slice end not concealed");

  // ready must stay low for the whole slice, or a second command
  // could overwrite the walk position mid-slice
  property p_busy_not_ready;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (state_q != ST_IDLE) |-> !o_cmd_ready;
  endproperty
  a_busy_not_ready: assert property (p_busy_not_ready)
    else $error("command ready while a slice is open");

  property p_clean_decoded;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      (state_q == ST_DECODE && i_dec_ctb_done && !i_dec_ctb_error)
        |=> (o_ctb_valid && o_ctb.mode == BUILD_DECODED
             && o_ctb.row == $past(row_q));
  endproperty
  a_clean_decoded: assert property (p_clean_decoded)
    else $error("decoded ctb not written out as decoded");

  property p_done_ready;
    @(posedge i_clk_sys) disable iff (!i_rstn)
      o_slice_done |-> o_cmd_ready;
  endproperty
  a_done_ready: assert property (p_done_ready)
    else $error("slice done without command ready");

  c_conceal_i: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    state_q == ST_CONCEAL && kind_q == SLICE_I);
  c_forced: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_ctb_valid && o_ctb.mode == BUILD_FORCED);
  c_clean: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    state_q == ST_DECODE && at_end && i_dec_ctb_done);
  c_conceal_skip: cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    o_ctb_valid && o_ctb.mode == BUILD_SKIP);

endmodule

// *** dv/slice_host_model.sv ***
// partner: host and parser model driving slice commands and ctb pulses
`timescale 1ns/10ps
module slice_host_model
  import conceal_pkg::*;
(
  // clock and handshake
  input wire logic i_clk_sys,
  input wire logic i_cmd_ready,
  // command and parser pulses
  output logic o_cmd_valid,
  output slice_cmd_s o_cmd,
  output logic o_dec_ctb_done,
  output logic o_dec_ctb_error,
  output logic o_dec_slice_end
);
  // ============================================
  // idle levels from time zero
  // ============================================
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd = '0;
    o_dec_ctb_done = 1'b0;
    o_dec_ctb_error = 1'b0;
    o_dec_slice_end = 1'b0;
  end

  // hold one command until taken, called just after an edge
  task automatic issue(input slice_cmd_s c);
    int k;
    o_cmd_valid = 1'b1;
    o_cmd = c;
    for (k = 0; k < 200 && i_cmd_ready !== 1'b1; k++) begin
      @(posedge i_clk_sys);
      #1;
    end
    @(posedge i_clk_sys);
    #1;
    o_cmd_valid = 1'b0;
    // released bus shows no stale value
    o_cmd = ~c;
  endtask

  // n decoded ctbs back to back, then error (1) or early end (2)
  task automatic parse(input int n, input int endk);
    repeat (n) begin
      o_dec_ctb_done = 1'b1;
      @(posedge i_clk_sys);
      #1;
    end
    o_dec_ctb_done = 1'b0;
    o_dec_ctb_error = (endk == 1);
    o_dec_slice_end = (endk == 2);
    @(posedge i_clk_sys);
    #1;
    o_dec_ctb_error = 1'b0;
    o_dec_slice_end = 1'b0;
  endtask
endmodule

// *** dv/slice_conceal_bench.sv ***
// bench: slice walks, clean and errored, for every slice kind
`timescale 1ns/10ps
module slice_conceal_bench;
  import conceal_pkg::*;
  // small picture keeps every walk short
  localparam int PW = 5;
  localparam int PH = 3;
  logic clk, rstn, cmd_valid, cmd_ready, dn, er, se, ctb_valid, sl_done;
  logic [CTB_W-1:0] pw, ph;
  slice_cmd_s cmd;
  ctb_out_s ctb;
  ctb_out_s seen[$];
  int err_total, comparisons, done_seen;

  slice_conceal #(.W(CTB_W)) slice_conceal_i (.i_clk_sys(clk),
    .i_rstn(rstn), .i_pic_width_ctb(pw), .i_pic_height_ctb(ph),
    .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_ready(cmd_ready),
    .i_dec_ctb_done(dn), .i_dec_ctb_error(er), .i_dec_slice_end(se),
    .o_ctb_valid(ctb_valid), .o_ctb(ctb), .o_slice_done(sl_done));
  slice_host_model slice_host_model_i (.i_clk_sys(clk),
    .i_cmd_ready(cmd_ready), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
    .o_dec_ctb_done(dn), .o_dec_ctb_error(er), .o_dec_slice_end(se));

  // ============================================
  // clock and output collector
  // ============================================
  always #20 clk = ~clk;
  always @(posedge clk) begin
    if (ctb_valid === 1'b1) seen.push_back(ctb);
    if (sl_done === 1'b1) done_seen++;
  end

  task automatic check(input string what, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", what, e, g);
      err_total++;
    end
  endtask

  task automatic close_out;
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one slice: n decoded, then end kind; whole ctb list is judged
  task automatic run_slice(input int cc, cr, nc, nr, fin,
                           input slice_kind_e kind, input int n, endk);
    slice_cmd_s c;
    ctb_out_s e;
    int first, last, i, k;
    c = '{CTB_W'(cc), CTB_W'(cr), CTB_W'(nc), CTB_W'(nr), fin[0], kind};
    seen.delete();
    done_seen = 0;
    slice_host_model_i.issue(c);
    check("cmd taken", 0, 32'(cmd_ready));
    slice_host_model_i.parse(n, endk);
    for (k = 0; k < 100 && done_seen == 0; k++) begin
      @(posedge clk);
      #1;
    end
    if (done_seen == 0) begin
      check("slice_done", 1, 0);
      close_out();
    end
    repeat (3) @(posedge clk);
    #1;
    check("done pulses", 1, done_seen);
    check("cmd_ready", 1, 32'(cmd_ready));
    first = cr * PW + cc;
    last = fin ? PW * PH - 1 : nr * PW + nc - 1;
    check("ctb count", last - first + 1, seen.size());
    for (i = first; i <= last && i - first < seen.size(); i++) begin
      e.col = CTB_W'(i % PW);
      e.row = CTB_W'(i / PW);
      if (i - first < n) e.mode = BUILD_DECODED;
      else if (i - first == n && endk == 1) e.mode = BUILD_FORCED;
      else if (kind == SLICE_I) e.mode = BUILD_PLANAR;
      else e.mode = BUILD_SKIP;
      check("ctb", 32'(e), 32'(seen[i - first]));
    end
  endtask

  // ============================================
  // scenarios
  // ============================================
  task automatic sc_idle_pulses;
    seen.delete();
    slice_host_model_i.parse(2, 1);
    repeat (3) @(posedge clk);
    #1;
    check("idle ctbs", 0, seen.size());
  endtask
  task automatic sc_clean;
    run_slice(0, 0, 2, 1, 0, SLICE_P, 7, 0);
  endtask
  task automatic sc_error_intra;
    run_slice(1, 1, 2, 2, 0, SLICE_I, 1, 1);
  endtask
  task automatic sc_end_pred;
    run_slice(2, 2, 4, 2, 0, SLICE_P, 0, 2);
  endtask
  task automatic sc_final_bi;
    run_slice(1, 2, 0, 0, 1, SLICE_B, 1, 1);
  endtask

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    pw = CTB_W'(PW);
    ph = CTB_W'(PH);
    err_total = 0;
    comparisons = 0;
    done_seen = 0;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    check("ready after reset", 1, 32'(cmd_ready));
    sc_idle_pulses();
    sc_clean();
    sc_error_intra();
    sc_end_pred();
    sc_final_bi();
    close_out();
  end
endmodule
